//--- fadd_pkg.sv
// Shared constants, register map and sequencer states of the float add/subtract block
package fadd_pkg;
    // Register byte offsets on the Avalon-MM slave
    localparam logic [4:0] OFS_CTRL = 5'h00;
    localparam logic [4:0] OFS_STATUS = 5'h04;
    localparam logic [4:0] OFS_EXP = 5'h08;
    localparam logic [4:0] OFS_FRAC_LO = 5'h0C;
    localparam logic [4:0] OFS_FRAC_HI = 5'h10;
    // Control and status field positions
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_SUB_BIT = 1;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_IRQ_BIT = 1;
    localparam int STAT_CARRY_BIT = 2;
    localparam int STAT_SIGN_BIT = 3;
    // Operand word layout: sign, excess-128 exponent, high fraction field
    localparam int WORD_SIGN_BIT = 15;
    localparam int WORD_EXP_MSB = 14;
    localparam int WORD_EXP_LSB = 7;
    localparam int WORD_HFRAC_MSB = 6;
    // Fraction register layout: bit 47 sign/overflow, bit 46 normalized one
    localparam int FRAC_W = 48;
    localparam int FRAC_SIGN_BIT = 47;
    localparam int FRAC_NORM_BIT = 46;
    localparam int MULQ_HIGH_LSB = 40;
    localparam int MULQ_LOW_LSB = 24;
    localparam int EXP_W = 8;
    // Alignment limit and its twos complement, used as a carry test
    localparam logic [7:0] ALIGN_LIMIT = 8'h17;
    localparam logic [7:0] ALIGN_LIMIT_NEG = 8'hE9;
    localparam logic [7:0] EXP_MAX = 8'hFF;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    // Microsequence steps
    typedef enum logic [4:0] {
        ST_IDLE = 5'h00, ST_FETCH = 5'h01, ST_CMP = 5'h02, ST_NEG = 5'h03,
        ST_LRG3 = 5'h04, ST_LRG4 = 5'h05, ST_SKIP = 5'h06, ST_ALIGN = 5'h07,
        ST_SUB = 5'h08, ST_NORM = 5'h09, ST_FIN = 5'h0A, ST_UFL = 5'h0B,
        ST_NL3 = 5'h0C, ST_NL4 = 5'h0D, ST_ADD6 = 5'h0E, ST_ADD7 = 5'h0F,
        ST_ADD8 = 5'h10, ST_OFL = 5'h11, ST_ZERO = 5'h12
    } seq_state_e;
endpackage

//--- float_add_sub_align_sequencer.sv
// Microsequenced single-precision float add/subtract datapath with Avalon-MM registers
`timescale 1ns/10ps

// How it works
// (RULE1) First step loads high fraction, sign into new-sign
// (RULE2) Exponent difference to shift counter, carry when nonnegative
// (RULE3) Compare step clears the constant register
// (RULE4) Next step negates count when carry was low
// (RULE5) Same subtraction always tests count for zero
// (RULE6) Second step waits for word two, then releases host
// (RULE7) Carry set at compare selects not-larger path
// (RULE8) Larger path loads word two, tests count against 23
// (RULE9) New fraction into A, swap sign flags
// (RULE10) Exponent plus count gives larger exponent
// (RULE11) Difference of 23 or more copies A to B
// (RULE12) Align B right, one shift per clock
// (RULE13) Equal signs add, different signs subtract
// (RULE14) Subtract A minus B, normalize, copy to B
// (RULE15) Normalization underflow zeroes result, sets interrupt flag
// (RULE16) Not-larger path moves mul-quot to B, clears zero
// (RULE17) Not-larger path aligns with zero flag frozen
// (RULE18) Add into A and B, test exponent overflow
// (RULE19) Sign-bit overflow shifts right, increments exponent
// (RULE20) Exponent overflow loads maximum, sets interrupt flag
// (RULE21) Normalize until bit 46 set, decrement exponent
// (RULE22) Fraction registers are 48 bits wide
// (RULE23) Operation starts by fetching the first word
module float_add_sub_align_sequencer
    import fadd_pkg::*;
(
    // Clock and reset
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    // Avalon-MM slave
    input wire logic [4:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // Operand memory access and host hand-back
    output logic mem_req_o,
    input wire logic mem_ack_i,
    input wire logic [15:0] mem_data_i,
    output logic host_release_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Storage
    seq_state_e state;
    seq_state_e next_state;
    logic [FRAC_W-1:0] a_reg; // [RULE22]
    logic [FRAC_W-1:0] b_reg;
    logic [FRAC_W-1:0] mul_quot_reg;
    logic [FRAC_W-1:0] constant_reg;
    logic [EXP_W-1:0] exp_reg;
    logic [EXP_W-1:0] shift_counter;
    logic [15:0] data_latch;
    logic exp_carry_flag;
    logic new_sign_flag;
    logic result_sign_flag;
    logic zero_flag;
    logic zero_hold;
    logic op_sub;
    logic irq_flag;

    // Merge write data into a register under byte enables
    function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode
    wire bus_req = avs_read_i | avs_write_i;
    wire bus_take = bus_req & ~avs_waitrequest_o;
    wire wr_take = bus_take & avs_write_i;
    wire busy = (state != ST_IDLE);
    wire wr_ctrl = wr_take & (avs_address_i == OFS_CTRL);
    wire wr_status = wr_take & (avs_address_i == OFS_STATUS);
    // Bus writes to the operand registers are ignored while a sequence runs
    wire wr_exp = wr_take & (avs_address_i == OFS_EXP) & ~busy;
    wire wr_flo = wr_take & (avs_address_i == OFS_FRAC_LO) & ~busy;
    wire wr_fhi = wr_take & (avs_address_i == OFS_FRAC_HI) & ~busy;
    wire [31:0] ctrl_word = be_merge(RESET_WORD, avs_writedata_i, avs_byteenable_i);
    wire start_req = wr_ctrl & ctrl_word[CTRL_START_BIT] & ~busy;
    wire irq_clear = wr_status & ctrl_word[STAT_IRQ_BIT];
    wire [31:0] frac_lo_new = be_merge(a_reg[31:0], avs_writedata_i, avs_byteenable_i);
    wire [31:0] frac_hi_new = be_merge({16'h0000, a_reg[47:32]}, avs_writedata_i,
                                       avs_byteenable_i);
    wire [31:0] exp_new = be_merge({24'h000000, exp_reg}, avs_writedata_i, avs_byteenable_i);
    wire [31:0] status_word = {28'h0000000, result_sign_flag, exp_carry_flag, irq_flag, busy};
    logic [31:0] rd_mux;

    // Read selection; unmapped offsets read as zero
    always_comb begin
        case (avs_address_i)
            OFS_CTRL: rd_mux = {30'h0, op_sub, busy};
            OFS_STATUS: rd_mux = status_word;
            OFS_EXP: rd_mux = {24'h000000, exp_reg};
            OFS_FRAC_LO: rd_mux = a_reg[31:0];
            OFS_FRAC_HI: rd_mux = {16'h0000, a_reg[47:32]};
            default: rd_mux = RESET_WORD;
        endcase
    end

    // One wait cycle per access; waitrequest drops for the completing edge only
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o <= RESET_WORD;
        end else begin
            avs_waitrequest_o <= ~(bus_req & avs_waitrequest_o);
            avs_readdata_o <= rd_mux;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Datapath terms
    wire [EXP_W-1:0] dl_exp = data_latch[WORD_EXP_MSB:WORD_EXP_LSB];
    wire [EXP_W:0] cmp_diff = {1'b0, exp_reg} - {1'b0, dl_exp};
    wire [EXP_W:0] limit_sum = {1'b0, shift_counter} + {1'b0, ALIGN_LIMIT_NEG};
    wire count_ge_limit = limit_sum[EXP_W]; // Carry means count >= 23
    wire [EXP_W-1:0] count_neg = 8'h00 - shift_counter;
    wire count_zero = (shift_counter == 8'h00);
    wire [EXP_W:0] exp_inc = {1'b0, exp_reg} + 9'h001;
    wire [FRAC_W-1:0] sum_ab = a_reg + b_reg;
    wire [FRAC_W-1:0] diff_ab = a_reg - b_reg;
    wire diff_neg = diff_ab[FRAC_SIGN_BIT];
    wire [FRAC_W-1:0] diff_mag = diff_neg ? (48'h0 - diff_ab) : diff_ab;
    wire signs_equal = (new_sign_flag == result_sign_flag);
    wire need_lshift = ~a_reg[FRAC_NORM_BIT];
    wire exp_at_floor = (exp_reg == 8'h00);

    ////////////////////////////////////////////////////////////////////////////
    // Next step selection
    always_comb begin
        case (state)
            ST_IDLE: next_state = start_req ? ST_FETCH : ST_IDLE; // [RULE23]
            ST_FETCH: next_state = mem_ack_i ? ST_CMP : ST_FETCH;
            ST_CMP: next_state = ST_NEG;
            // Branch uses the carry of the compare, not the zero test result
            ST_NEG: begin
                if (!mem_ack_i) begin
                    next_state = ST_NEG; // [RULE6]
                end else begin
                    next_state = exp_carry_flag ? ST_NL3 : ST_LRG3; // [RULE7]
                end
            end
            ST_LRG3: next_state = ST_LRG4;
            ST_LRG4: next_state = exp_carry_flag ? ST_SKIP : ST_ALIGN; // [RULE11]
            ST_NL3: next_state = ST_NL4;
            ST_NL4: next_state = exp_carry_flag ? ST_SKIP : ST_ALIGN;
            ST_ALIGN: begin
                if (!count_zero) begin
                    next_state = ST_ALIGN; // [RULE12]
                end else begin
                    next_state = signs_equal ? ST_ADD6 : ST_SUB; // [RULE13] [RULE17]
                end
            end
            ST_SUB: next_state = (diff_ab == 48'h0) ? ST_ZERO : ST_NORM;
            ST_NORM: next_state = (need_lshift && !exp_at_floor) ? ST_NORM : ST_FIN;
            ST_FIN: next_state = exp_carry_flag ? ST_UFL : ST_IDLE; // [RULE15]
            ST_ADD6: next_state = ST_ADD7;
            ST_ADD7: next_state = (a_reg[FRAC_SIGN_BIT] | zero_flag) ? ST_ADD8 : ST_IDLE;
            ST_ADD8: next_state = exp_carry_flag ? ST_OFL : ST_IDLE; // [RULE19]
            default: next_state = ST_IDLE;
        endcase
    end

    // Sequencer state, memory request and host release
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state <= ST_IDLE;
            mem_req_o <= 1'b0;
            host_release_o <= 1'b0;
            data_latch <= 16'h0000;
        end else begin
            state <= next_state;
            mem_req_o <= (next_state == ST_FETCH) | (next_state == ST_NEG);
            host_release_o <= (state == ST_NEG) & mem_ack_i; // [RULE6]
            if (mem_req_o && mem_ack_i) begin
                data_latch <= mem_data_i;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control flags; a new interrupt event wins over a software clear
    wire irq_event = (state == ST_UFL) | (state == ST_OFL);
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            irq_flag <= 1'b0;
            op_sub <= 1'b0;
        end else begin
            irq_flag <= irq_event | (irq_flag & ~irq_clear); // [RULE15] [RULE20]
            if (start_req) begin
                op_sub <= ctrl_word[CTRL_SUB_BIT];
            end
        end
    end

    // Shift counter and exponent-carry flag
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            shift_counter <= 8'h00;
            exp_carry_flag <= 1'b0;
        end else begin
            case (state)
                ST_CMP: begin
                    shift_counter <= cmp_diff[EXP_W-1:0]; // [RULE2]
                    exp_carry_flag <= ~cmp_diff[EXP_W];
                end
                ST_NEG: begin
                    if (mem_ack_i) begin
                        if (!exp_carry_flag) begin
                            shift_counter <= count_neg; // [RULE4]
                        end
                        exp_carry_flag <= count_zero; // [RULE5]
                    end
                end
                ST_LRG3, ST_NL3: exp_carry_flag <= count_ge_limit; // [RULE8]
                ST_ALIGN: begin
                    if (!count_zero) begin
                        shift_counter <= shift_counter - 8'h01; // [RULE12]
                    end
                end
                ST_SUB: exp_carry_flag <= 1'b0;
                ST_NORM: exp_carry_flag <= need_lshift & exp_at_floor; // [RULE15]
                ST_ADD7: exp_carry_flag <= exp_inc[EXP_W]; // [RULE18]
                default: exp_carry_flag <= exp_carry_flag;
            endcase
        end
    end

    // Sign and zero flags
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            new_sign_flag <= 1'b0;
            result_sign_flag <= 1'b0;
            zero_flag <= 1'b0;
            zero_hold <= 1'b0;
        end else begin
            if (state == ST_CMP) begin
                new_sign_flag <= data_latch[WORD_SIGN_BIT] ^ op_sub; // [RULE1]
                zero_hold <= 1'b0;
            end else if (state == ST_LRG4) begin
                new_sign_flag <= result_sign_flag; // [RULE9]
                result_sign_flag <= new_sign_flag;
            end else if (state == ST_NL4) begin
                zero_flag <= 1'b0; // [RULE16]
                zero_hold <= 1'b1; // [RULE17]
            end else if (state == ST_SUB && diff_neg) begin
                result_sign_flag <= ~result_sign_flag;
            end else if (state == ST_ZERO) begin
                result_sign_flag <= 1'b0;
            end else if (state == ST_ADD6 && !zero_hold) begin
                zero_flag <= (sum_ab == 48'h0);
            end else if (wr_status) begin
                result_sign_flag <= ctrl_word[STAT_SIGN_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Fraction and exponent registers
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            a_reg <= 48'h0;
            b_reg <= 48'h0;
            mul_quot_reg <= 48'h0;
            constant_reg <= 48'h0;
            exp_reg <= 8'h00;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (wr_flo) begin
                        a_reg[31:0] <= frac_lo_new;
                        b_reg[31:0] <= frac_lo_new;
                    end
                    if (wr_fhi) begin
                        a_reg[47:32] <= frac_hi_new[15:0];
                        b_reg[47:32] <= frac_hi_new[15:0];
                    end
                    if (wr_exp) begin
                        exp_reg <= exp_new[EXP_W-1:0];
                    end
                end
                ST_CMP: begin
                    mul_quot_reg <= {1'b0, data_latch[WORD_HFRAC_MSB:0], 40'h0}; // [RULE1]
                    constant_reg <= 48'h0; // [RULE3]
                end
                ST_LRG3, ST_NL3: mul_quot_reg[MULQ_HIGH_LSB-1:MULQ_LOW_LSB] <= data_latch; // [RULE8]
                ST_LRG4: begin
                    a_reg <= mul_quot_reg; // [RULE9]
                    exp_reg <= exp_reg + shift_counter; // [RULE10]
                end
                ST_NL4: b_reg <= mul_quot_reg; // [RULE16]
                ST_SKIP: b_reg <= a_reg; // [RULE11]
                ST_ALIGN: begin
                    if (!count_zero) begin
                        b_reg <= b_reg >> 1; // [RULE12]
                    end
                end
                ST_SUB: a_reg <= diff_mag; // [RULE14]
                ST_NORM: begin
                    if (need_lshift && !exp_at_floor) begin
                        a_reg <= a_reg << 1; // [RULE21]
                        exp_reg <= exp_reg - 8'h01;
                    end
                end
                ST_FIN: b_reg <= a_reg; // [RULE14]
                ST_ADD6: begin
                    a_reg <= sum_ab; // [RULE18]
                    b_reg <= sum_ab;
                end
                ST_ADD8: begin
                    a_reg <= a_reg >> 1; // [RULE19]
                    b_reg <= b_reg >> 1;
                    exp_reg <= exp_inc[EXP_W-1:0];
                    constant_reg <= 48'h8000_0000_0000;
                end
                ST_OFL: begin
                    a_reg <= constant_reg - 48'h1; // [RULE20]
                    b_reg <= constant_reg - 48'h1;
                    exp_reg <= EXP_MAX;
                end
                ST_UFL, ST_ZERO: begin
                    a_reg <= 48'h0; // [RULE15]
                    b_reg <= 48'h0;
                    exp_reg <= 8'h00;
                end
                default: exp_reg <= exp_reg;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);

    AST_SIGN_LOAD: assert property (state == ST_CMP |=> // [RULE1]
        new_sign_flag == ($past(data_latch[WORD_SIGN_BIT]) ^ op_sub))
        else $error("new sign not loaded from operand");
    AST_CMP_DIFF: assert property (state == ST_CMP |=> // [RULE2]
        shift_counter == $past(cmp_diff[EXP_W-1:0]) && exp_carry_flag == !$past(cmp_diff[EXP_W]))
        else $error("exponent compare wrong");
    AST_CR_CLEAR: assert property (state == ST_CMP |=> constant_reg == 48'h0) // [RULE3]
        else $error("constant register not cleared");
    AST_NEGATE: assert property (state == ST_NEG && mem_ack_i && !exp_carry_flag |=> // [RULE4]
        shift_counter == 8'h00 - $past(shift_counter))
        else $error("shift count not negated");
    AST_ZERO_TEST: assert property (state == ST_NEG && mem_ack_i |=> // [RULE5]
        exp_carry_flag == ($past(shift_counter) == 8'h00))
        else $error("zero test of shift count wrong");
    AST_HOLD_WORD2: assert property (state == ST_NEG && !mem_ack_i |=> // [RULE6]
        state == ST_NEG && !host_release_o)
        else $error("second step ended without memory cycle");
    AST_BRANCH: assert property (state == ST_NEG && mem_ack_i |=> // [RULE7]
        (state == ST_NL3) == $past(exp_carry_flag) && host_release_o)
        else $error("branch after second step wrong");
    AST_ALIGN_STEP: assert property (state == ST_ALIGN && !count_zero |=> // [RULE12]
        b_reg == ($past(b_reg) >> 1) && shift_counter == $past(shift_counter) - 8'h01)
        else $error("alignment step wrong");
    AST_NORM_STEP: assert property (state == ST_NORM && need_lshift && !exp_at_floor // [RULE21]
        |=> exp_reg == $past(exp_reg) - 8'h01 && a_reg == ($past(a_reg) << 1))
        else $error("normalization step wrong");
    AST_OVERFLOW: assert property (state == ST_ADD8 && exp_carry_flag |=> ##1 // [RULE20]
        irq_flag && exp_reg == EXP_MAX && a_reg == 48'h7FFF_FFFF_FFFF)
        else $error("overflow result wrong");

endmodule

//--- host_mem_model.sv
// Behavioural host memory that hands operand words to the block
`timescale 1ns/10ps
module host_mem_model (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    // Request from the block, words to hand out, answer delay
    input wire logic req_i,
    input wire logic [15:0] word1_i,
    input wire logic [15:0] word2_i,
    input wire logic [3:0] delay_i,
    // Answer to the block
    output logic ack_o,
    output logic [15:0] data_o
);
    logic [3:0] wait_cnt;
    logic second;
    ////////////////////////////////////////////////////////////////////////////////
    // One ack pulse per request after delay_i cycles; data churns so stale words never pass
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ack_o <= 1'b0;
            data_o <= 16'hA5A5;
            wait_cnt <= 4'h0;
            second <= 1'b0;
        end else if (req_i && !ack_o && wait_cnt >= delay_i) begin
            ack_o <= 1'b1;
            data_o <= second ? word2_i : word1_i;
            second <= ~second;
            wait_cnt <= 4'h0;
        end else begin
            ack_o <= 1'b0;
            data_o <= ~data_o; // Released bus holds no valid word
            wait_cnt <= (req_i && !ack_o) ? wait_cnt + 4'h1 : 4'h0;
        end
    end
endmodule

//--- test_float_add_sub_align_sequencer.sv
// Self-checking bench of the float add/subtract sequencer
`timescale 1ns/10ps
module test_float_add_sub_align_sequencer
    import fadd_pkg::*;
;
    logic mclk_i, sys_rst_i, avs_read_i, avs_write_i, avs_waitrequest_o;
    logic mem_req_o, mem_ack_i, host_release_o;
    logic [4:0] avs_address_i;
    logic [31:0] avs_writedata_i, avs_readdata_o, rd;
    logic [15:0] mem_data_i, word1, word2;
    logic [3:0] delay;
    int fail_count, checks, cycles, releases;
    ////////////////////////////////////////////////////////////////////////////////
    // Design and far-side memory
    float_add_sub_align_sequencer uut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_byteenable_i(4'hF), .avs_writedata_i(avs_writedata_i),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .mem_req_o(mem_req_o), .mem_ack_i(mem_ack_i), .mem_data_i(mem_data_i),
        .host_release_o(host_release_o));
    host_mem_model mem (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .req_i(mem_req_o),
        .word1_i(word1), .word2_i(word2), .delay_i(delay), .ack_o(mem_ack_i),
        .data_o(mem_data_i));
    ////////////////////////////////////////////////////////////////////////////////
    // Clock, hang guard and hand-back pulse counter
    initial begin
        mclk_i = 1'b0;
        forever #20 mclk_i = ~mclk_i;
    end
    always @(posedge mclk_i) begin
        cycles++;
        if (host_release_o === 1'b1) releases++;
        if (cycles == 20000) begin
            fail_count++;
            close_out;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Compare, bus and verdict tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_cnt(input int got, input int exp);
        checks++;
        if (got != exp) begin
            fail_count++;
            $display("Error at %0t: pulses %h expected %h", $time, got, exp);
        end
    endtask
    // Request held until the edge that samples waitrequest low
    task automatic bus(input logic wr, input logic [4:0] addr, input logic [31:0] wd);
        @(posedge mclk_i);
        avs_address_i <= addr;
        avs_write_i <= wr;
        avs_read_i <= !wr;
        avs_writedata_i <= wd;
        do @(posedge mclk_i); while (avs_waitrequest_o !== 1'b0);
        rd = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask
    task automatic close_out;
        $display("Comparisons %0d, mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Preload previous result, run one operation, compare result and masked status
    task automatic run_op(input logic [7:0] e0, input logic [47:0] f0, input logic s0,
        input logic [15:0] w1, input logic [15:0] w2, input logic sub, input logic [3:0] dly,
        input logic [7:0] ee, input logic [47:0] ef, input logic [31:0] est,
        input logic [31:0] msk);
        int n;
        bus(1'b1, OFS_EXP, {24'h0, e0});
        bus(1'b1, OFS_FRAC_LO, f0[31:0]);
        bus(1'b1, OFS_FRAC_HI, {16'h0, f0[47:32]});
        bus(1'b1, OFS_STATUS, {28'h0, s0, 3'h2});
        word1 <= w1;
        word2 <= w2;
        delay <= dly;
        releases = 0;
        bus(1'b1, OFS_CTRL, {30'h0, sub, 1'b1});
        n = 0;
        do begin
            bus(1'b0, OFS_STATUS, 32'h0);
            n++;
        end while (rd[STAT_BUSY_BIT] !== 1'b0 && n < 200);
        chk({31'h0, rd[STAT_BUSY_BIT]}, 32'h0);
        chk_cnt(releases, 1);
        bus(1'b0, OFS_EXP, 32'h0);
        chk(rd, {24'h0, ee});
        bus(1'b0, OFS_FRAC_LO, 32'h0);
        chk(rd, ef[31:0]);
        bus(1'b0, OFS_FRAC_HI, 32'h0);
        chk(rd, {16'h0, ef[47:32]});
        bus(1'b0, OFS_STATUS, 32'h0);
        chk(rd & msk, est & msk);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset;
        chk({31'h0, avs_waitrequest_o}, 32'h1);
        bus(1'b0, OFS_STATUS, 32'h0);
        chk(rd, 32'h0);
        bus(1'b1, 5'h14, 32'hFFFF_FFFF);
        bus(1'b0, 5'h14, 32'h0);
        chk(rd, 32'h0);
    endtask
    // +7 plus +1: smaller new operand aligned by two, sum overflows bit 47
    task automatic t_add_small;
        run_op(8'h83, 48'h7000_0000_0000, 1'b0, 16'h40C0, 16'h0, 1'b0, 4'h0, 8'h84,
            48'h4000_0000_0000, 32'h0, 32'hA);
    endtask
    // +1 minus +7: larger new exponent, sign inverted, different-sign subtract
    task automatic t_sub_larger;
        run_op(8'h81, 48'h4000_0000_0000, 1'b0, 16'h41F0, 16'h0, 1'b1, 4'h3, 8'h83,
            48'h6000_0000_0000, 32'h8, 32'hA);
    endtask
    // Difference of exactly 23: alignment skipped, word two kept in the fraction
    task automatic t_skip;
        run_op(8'h80, 48'h4000_0000_0000, 1'b1, 16'h4BC0, 16'h1234, 1'b0, 4'h1, 8'h97,
            48'h4012_3400_0000, 32'h4, 32'hE);
    endtask
    // Sum at the top exponent overflows; interrupt flag then cleared by software
    task automatic t_overflow;
        run_op(8'hFF, 48'h6000_0000_0000, 1'b0, 16'h7F60, 16'h0, 1'b0, 4'h2, 8'hFF,
            48'h7FFF_FFFF_FFFF, 32'h6, 32'h6);
        bus(1'b1, OFS_STATUS, 32'h2);
        bus(1'b0, OFS_STATUS, 32'h0);
        chk(rd & 32'h2, 32'h0);
    endtask
    // Normalization reaches exponent zero with bit 46 still clear: underflow
    task automatic t_underflow;
        run_op(8'h00, 48'h6000_0000_0000, 1'b0, 16'h80C0, 16'h0, 1'b0, 4'h0, 8'h00,
            48'h0, 32'h6, 32'h6);
    endtask
    // Equal exponents: +1 minus +1 gives clean zero, +1 minus +1.5 flips the result sign
    task automatic t_equal_exp;
        run_op(8'h81, 48'h4000_0000_0000, 1'b0, 16'h40C0, 16'h0, 1'b1, 4'h1, 8'h00,
            48'h0, 32'h0, 32'hE);
        run_op(8'h81, 48'h4000_0000_0000, 1'b0, 16'h40E0, 16'h0, 1'b1, 4'h0, 8'h80,
            48'h4000_0000_0000, 32'h8, 32'hE);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        sys_rst_i = 1'b1;
        avs_address_i = 5'h00;
        avs_read_i = 1'b0;
        avs_write_i = 1'b0;
        avs_writedata_i = 32'h0;
        word1 = 16'h0;
        word2 = 16'h0;
        delay = 4'h0;
        repeat (4) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        t_reset;
        t_add_small;
        t_sub_larger;
        t_skip;
        t_overflow;
        t_underflow;
        t_equal_exp;
        close_out;
    end
endmodule
